// ===== dv/sram_scan_asserts.sv
// Link assertions for the SRAM and its controller
`timescale 1ns/1ps
`default_nettype none
`include "sram_scan_map.svh"
module sram_scan_asserts (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rstn,
    // Array pins
    input wire logic              array_clock,
    input wire logic [`DATA_W-1:0] din_bus,
    input wire logic              write_strobe_n,
    input wire logic              output_drive_n,
    input wire logic [`DATA_W-1:0] dout_bus,
    input wire logic              dout_oe,
    // Scan pins
    input wire logic              scan_clk,
    input wire logic              scan_capture_hold,
    input wire logic              scan_out
);
    localparam int RECOV = `SCAN_RECOV_CYC;
    logic [4:0] quiet_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Saturates so a long idle spell never wraps back under the limit
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            quiet_q <= 5'h1f;
        end else if (scan_clk || scan_capture_hold) begin
            quiet_q <= 5'h00;
        end else if (quiet_q != 5'h1f) begin
            quiet_q <= quiet_q + 5'h01;
        end
    end

    sequence op_edge;
        $rose(array_clock);
    endsequence
    sequence half_high;
        ##1 array_clock ##1 !array_clock;
    endsequence

    write_pass_a: assert property (op_edge ##0 !write_strobe_n |->
        ##6 dout_bus == $past(din_bus, 6)) else $error("pass-through word wrong");
    drive_follow_a: assert property (op_edge |->
        ##2 dout_oe == !$past(output_drive_n, 2)) else $error("output drive wrong");
    clk_shape_a: assert property (op_edge |-> half_high)
        else $error("array clock high phase wrong");
    normal_quiet_a: assert property (array_clock |-> !scan_clk && !scan_capture_hold)
        else $error("scan pins active in normal operation");
    setup_gap_a: assert property ($rose(scan_clk) |->
        !$past(array_clock, 1) && !$past(array_clock, 2)) else $error("scan setup too short");
    hold_rise_a: assert property ($fell(scan_clk) && !scan_capture_hold |->
        ##[1:3] scan_capture_hold)
        else $error("capture hold not raised");
    shift_edge_a: assert property ($changed(scan_out) |-> !scan_clk)
        else $error("scan output moved while scan clock high");
    recovery_a: assert property (op_edge |-> quiet_q >= RECOV)
        else $error("array clock resumed too soon");
endmodule
`default_nettype wire

// ===== dv/test_sync_sram_passthrough_scan.sv
// Self-checking bench: controller and SRAM joined back to back
`timescale 1ns/1ps
`default_nettype none
`include "sram_scan_map.svh"
module test_sync_sram_passthrough_scan;
    logic clk_sys, rstn, req_valid, req_ready, req_drive, rsp_valid;
    logic scan_start, scan_busy, scan_done, scan_active, bypass_active;
    sram_scan_pkg::cmd_t req_cmd;
    logic [`ADDR_W-1:0] req_addr, a;
    logic [`DATA_W-1:0] req_wdata, rsp_data, d, mem_m [int];
    logic [38:0] scan_word, exp_q [$], scan_q [$];
    int fails = 0, check_count = 0, cycles = 0, seed = 78;
    int ord [39] = '{6, 4, 2, 0, 28, 38, 26, 36, 24, 34, 22, 32, 20, 30, 1, 3, 5, 7, 8, 9,
        10, 11, 12, 13, 31, 21, 33, 23, 35, 25, 37, 27, 15, 16, 14, 40, 41, 42, 43};

    sram_link_if link ();
    sram_device sram_device_i (.clk_sys(clk_sys), .rstn(rstn), .link(link.device),
        .scan_active(scan_active), .bypass_active(bypass_active));
    sram_host sram_host_i (.clk_sys(clk_sys), .rstn(rstn), .link(link.host),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_drive(req_drive),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .scan_start(scan_start),
        .scan_busy(scan_busy), .scan_done(scan_done), .scan_word(scan_word));
    sram_scan_asserts sram_scan_asserts_i (.clk_sys(clk_sys), .rstn(rstn),
        .array_clock(link.array_clock), .din_bus(link.din_bus),
        .write_strobe_n(link.write_strobe_n), .output_drive_n(link.output_drive_n),
        .dout_bus(link.dout_bus), .dout_oe(link.dout_oe), .scan_clk(link.scan_clk),
        .scan_capture_hold(link.scan_capture_hold), .scan_out(link.scan_out));

    always #2.5 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [38:0] e, input logic [38:0] s);
        check_count++;
        if (e !== s) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Valid stays up between calls, so back to back requests never toggle it
    task automatic op(input sram_scan_pkg::cmd_t c, input logic [16:0] ad,
                      input logic [8:0] wd, input logic dr);
        req_valid = 1'b1;
        req_cmd = c;
        req_addr = ad;
        req_wdata = wd;
        req_drive = dr;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        #1;
        if (dr) exp_q.push_back(39'(c == sram_scan_pkg::CMD_READ ? mem_m[ad] : wd));
        if (c == sram_scan_pkg::CMD_WRITE) mem_m[ad] = wd;
    endtask

    // Pin levels are taken while the array clock is parked, so they match the capture
    task automatic do_scan();
        logic [47:0] v;
        logic [38:0] e;
        scan_start = 1'b1;
        @(posedge clk_sys);
        #1 scan_start = 1'b0;
        while (link.scan_clk !== 1'b1) @(posedge clk_sys);
        v = '0;
        v[16:0] = link.addr_bus;
        v[28:20] = link.din_bus;
        v[38:30] = link.dout_oe ? link.dout_bus : 9'h000;
        v[43:40] = {link.array_clock, link.write_strobe_n, link.output_drive_n,
                    link.chip_select_n};
        for (int i = 0; i < 39; i++) e[i] = v[ord[i]];
        scan_q.push_back(e);
        repeat (2) @(posedge clk_sys);
        check("scan_active", 39'h1, 39'(scan_active));
        check("bypass_active", 39'h0, 39'(bypass_active));
        while (scan_busy !== 1'b0) @(posedge clk_sys);
        #1;
    endtask

    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1)
            check("rsp_data", exp_q.size() ? exp_q.pop_front() : 'x, 39'(rsp_data));
        if (scan_done === 1'b1)
            check("scan_word", scan_q.size() ? scan_q.pop_front() : 'x, scan_word);
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        req_valid = 1'b0;
        req_cmd = sram_scan_pkg::CMD_READ;
        req_addr = '0;
        req_wdata = '0;
        req_drive = 1'b0;
        scan_start = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 rstn = 1'b1;
        // Ends of the address range first, then random places
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? '0 : (i == 1) ? '1 : 17'($random(seed));
            d = 9'($random(seed));
            op(sram_scan_pkg::CMD_WRITE, a, d, i[0]);
            op(sram_scan_pkg::CMD_PASS, a, ~d, 1'b1);
            op(sram_scan_pkg::CMD_READ, a, 9'($random(seed)), 1'b1);
        end
        #5 req_valid = 1'b0;
        while (exp_q.size() != 0) @(posedge clk_sys);
        #1;
        do_scan();
        op(sram_scan_pkg::CMD_READ, a, 9'h000, 1'b1);
        #5 req_valid = 1'b0;
        while (exp_q.size() != 0 || scan_q.size() != 0) @(posedge clk_sys);
        check("scan_active", 39'h0, 39'(scan_active));
        close_out();
    end
endmodule
`default_nettype wire

// ===== verilog/scan_chain.sv
// Boundary scan register chain with its bypass shadow register
`timescale 1ns/1ps
`default_nettype none
`include "sram_scan_map.svh"
module scan_chain #(
    parameter int LEN = `CHAIN_LEN
) (
    // Clock and reset
    input  wire logic           clk_sys,
    input  wire logic           rstn,
    // Mode strobes
    input  wire logic           cap,
    input  wire logic           shift,
    input  wire logic           byp_sample,
    input  wire logic           byp_drive,
    // Data
    input  wire logic           scan_in,
    input  wire logic [LEN-1:0] cap_vec,
    output var  logic           scan_out
);
    logic [LEN-1:0] chain_q;
    logic           shadow_bypass_reg;

    // Bit 0 leaves first; the serial input refills the tail
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chain_q <= '0;
        end else if (cap) begin
            chain_q <= cap_vec;
        end else if (shift) begin
            chain_q <= {scan_in, chain_q[LEN-1:1]};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shadow_bypass_reg <= 1'b0;
        end else if (byp_sample) begin
            shadow_bypass_reg <= scan_in;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scan_out <= 1'b0;
        end else if (shift) begin
            scan_out <= chain_q[0];
        end else if (byp_drive) begin
            scan_out <= shadow_bypass_reg;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sram_device.sv
// Synchronous 128K x 9 SRAM core with pass-through and boundary scan
`timescale 1ns/1ps
`default_nettype none
`include "sram_scan_map.svh"
module sram_device #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W,
    parameter int DEPTH  = `MEM_DEPTH
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Link to the memory controller and test controller
    sram_link_if.device     link,
    // Mode status
    output var  logic       scan_active,
    output var  logic       bypass_active
);
    // Edge detection of the pin-level clocks
    logic                   ak_prev_q;
    logic                   sck_prev_q;
    logic                   ak_rise;
    logic                   sck_rise;
    logic                   sck_fall;
    logic                   scan_idle;
    logic                   norm_edge;

    // Input registers of the array
    logic [ADDR_W-1:0]      addr_q;
    logic [DATA_W-1:0]      din_q;
    logic                   we_n_q;
    logic                   cs_n_q;

    // Output register and storage
    logic [DATA_W-1:0]      dout_q;
    logic                   dout_oe_q;
    logic [DATA_W-1:0]      mem [DEPTH];
    logic                   do_write;

    // Scan control
    sram_scan_pkg::dev_mode_t mode_q;
    logic                   cap;
    logic                   shift;
    logic                   byp_sample;
    logic                   byp_drive;
    logic [DATA_W-1:0]      q_level;
    logic [`CHAIN_LEN-1:0]  cap_vec;
    logic [ADDR_W-1:0]      a;
    logic [DATA_W-1:0]      d;

    assign ak_rise   = link.array_clock & ~ak_prev_q;
    assign sck_rise  = link.scan_clk & ~sck_prev_q;
    assign sck_fall  = ~link.scan_clk & sck_prev_q;
    // The tester keeps both scan pins low outside scanning
    assign scan_idle = ~link.scan_clk & ~link.scan_capture_hold;

    // An array edge counts while in normal mode, or when it brings the part back
    assign norm_edge = ak_rise & ((mode_q == sram_scan_pkg::MODE_NORMAL) | scan_idle);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ak_prev_q  <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            ak_prev_q  <= link.array_clock;
            sck_prev_q <= link.scan_clk;
        end
    end

    // Address, data and controls all land on the same array edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_q <= '0;
            din_q  <= '0;
            we_n_q <= 1'b1;
            cs_n_q <= 1'b1;
        end else if (norm_edge) begin
            addr_q <= link.addr_bus;
            din_q  <= link.din_bus;
            we_n_q <= link.write_strobe_n;
            cs_n_q <= link.chip_select_n;
        end
    end

    // Writes complete on the edge after capture; select high blocks them
    assign do_write = norm_edge & ~we_n_q & ~cs_n_q;

    // Storage has no reset: contents are undefined until written
    always_ff @(posedge clk_sys) begin
        if (do_write) begin
            mem[addr_q] <= din_q;
        end
    end

    // Pass-through whenever the strobe was low, read otherwise; the read
    // sees the last written word because a write and a read never share an edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dout_q <= '0;
        end else if (norm_edge) begin
            if (!we_n_q) begin
                dout_q <= din_q;
            end else begin
                dout_q <= mem[addr_q];
            end
        end
    end

    // Drive follows only the output drive level taken on this same edge,
    // whatever chip select or strobe were
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dout_oe_q <= 1'b0;
        end else if (norm_edge) begin
            dout_oe_q <= ~link.output_drive_n;
        end
    end

    assign link.dout_bus = dout_q;
    assign link.dout_oe  = dout_oe_q;

    // Mode machine: capture on the first scan rise, bypass when the scan
    // clock keeps running with hold low, normal again on a quiet array edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_q <= sram_scan_pkg::MODE_NORMAL;
        end else if (ak_rise && scan_idle) begin
            mode_q <= sram_scan_pkg::MODE_NORMAL;
        end else begin
            case (mode_q)
                sram_scan_pkg::MODE_NORMAL: begin
                    if (sck_rise) begin
                        mode_q <= sram_scan_pkg::MODE_SCAN;
                    end
                end
                sram_scan_pkg::MODE_SCAN: begin
                    if (sck_rise && !link.scan_capture_hold) begin
                        mode_q <= sram_scan_pkg::MODE_BYPASS;
                    end
                end
                sram_scan_pkg::MODE_BYPASS: begin
                    mode_q <= sram_scan_pkg::MODE_BYPASS;
                end
                default: begin
                    mode_q <= sram_scan_pkg::MODE_NORMAL;
                end
            endcase
        end
    end

    // Raising hold after the capture keeps later rises from entering bypass; capture fires only in normal mode
    assign cap        = sck_rise & (mode_q == sram_scan_pkg::MODE_NORMAL);
    assign shift      = sck_fall & (mode_q == sram_scan_pkg::MODE_SCAN);
    assign byp_sample = sck_rise & ~link.scan_capture_hold
                        & (mode_q != sram_scan_pkg::MODE_NORMAL);
    assign byp_drive  = sck_fall & (mode_q == sram_scan_pkg::MODE_BYPASS);

    // Scanned data outputs show the pin level: zero while floating
    assign q_level = dout_oe_q ? dout_q : '0;
    assign a       = link.addr_bus;
    assign d       = link.din_bus;

    // Bit 0 is shifted out first; scan pins and supplies are not in the path
    assign cap_vec = {
        link.array_clock, link.write_strobe_n, link.output_drive_n,
        link.chip_select_n, a[14], a[16], a[15],
        d[7], q_level[7], d[5], q_level[5], d[3], q_level[3], d[1], q_level[1],
        a[13], a[12], a[11], a[10], a[9], a[8], a[7], a[5], a[3], a[1],
        q_level[0], d[0], q_level[2], d[2], q_level[4], d[4],
        q_level[6], d[6], q_level[8], d[8],
        a[0], a[2], a[4], a[6]
    };

    scan_chain #(
        .LEN        (`CHAIN_LEN)
    ) u_chain (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .cap        (cap),
        .shift      (shift),
        .byp_sample (byp_sample),
        .byp_drive  (byp_drive),
        .scan_in    (link.scan_in),
        .cap_vec    (cap_vec),
        .scan_out   (link.scan_out)
    );

    // Status flags for the user side
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scan_active   <= 1'b0;
            bypass_active <= 1'b0;
        end else begin
            scan_active   <= (mode_q == sram_scan_pkg::MODE_SCAN);
            bypass_active <= (mode_q == sram_scan_pkg::MODE_BYPASS);
        end
    end

    // The tester's waits around scanning are its own duty; this end ignores
    // array edges only while a scan pin is high, and relies on those gaps.
endmodule
`default_nettype wire

// ===== verilog/sram_host.sv
// Memory and scan controller driving the SRAM pins
`timescale 1ns/1ps
`default_nettype none
`include "sram_scan_map.svh"
module sram_host #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W,
    parameter int LEN    = `CHAIN_LEN
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Pins
    sram_link_if.host               link,
    // Memory requests
    input  wire logic               req_valid,
    output var  logic               req_ready,
    input  wire sram_scan_pkg::cmd_t req_cmd,
    input  wire logic [ADDR_W-1:0]  req_addr,
    input  wire logic [DATA_W-1:0]  req_wdata,
    input  wire logic               req_drive,
    output var  logic               rsp_valid,
    output var  logic [DATA_W-1:0]  rsp_data,
    // Scan requests
    input  wire logic               scan_start,
    output var  logic               scan_busy,
    output var  logic               scan_done,
    output var  logic [LEN-1:0]     scan_word
);
    sram_scan_pkg::host_state_t st_q;
    logic [7:0]          tmr_q;
    logic [5:0]          bits_q;
    logic                ak_q, sck_q, hold_q;
    logic [1:0]          akc_q;
    logic                tick, fall_en, take, start_scan, pend_q;
    logic                slot_q, sdrv_q, tag_a_q, tag_b_q;
    sram_scan_pkg::cmd_t scmd_q;
    logic [ADDR_W-1:0]   saddr_q;
    logic [DATA_W-1:0]   sdata_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   din_q;
    logic                cs_n_q, we_n_q, oe_n_q;

    assign tick       = (akc_q == 2'(`ARRAY_HALF_CYC - 1)) && (st_q == sram_scan_pkg::H_RUN);
    assign fall_en    = tick & ak_q;
    assign take       = req_valid & req_ready;
    // Scanning waits for the pipeline to drain so no read result is lost
    assign start_scan = fall_en & pend_q & ~slot_q & ~tag_a_q & ~tag_b_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            akc_q <= '0;
            ak_q  <= 1'b0;
        end else if (tick) begin
            akc_q <= '0;
            ak_q  <= ~ak_q & ~start_scan;
        end else if (st_q == sram_scan_pkg::H_RUN) begin
            akc_q <= akc_q + 2'h1;
        end
    end

    // A new scan request wins over the clear of the pending flag
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= scan_start | (pend_q & ~start_scan);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            slot_q  <= 1'b0;
            scmd_q  <= sram_scan_pkg::CMD_READ;
            saddr_q <= '0;
            sdata_q <= '0;
            sdrv_q  <= 1'b0;
        end else if (take) begin
            slot_q  <= 1'b1;
            scmd_q  <= req_cmd;
            saddr_q <= req_addr;
            sdata_q <= req_wdata;
            sdrv_q  <= req_drive;
        end else if (fall_en) begin
            slot_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= ~slot_q & ~take & ~pend_q & ~scan_start & (st_q == sram_scan_pkg::H_RUN);
        end
    end

    // Pins change on the array clock fall; output drive lags one cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_q <= '0;
            din_q  <= '0;
            cs_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            tag_a_q <= 1'b0;
            tag_b_q <= 1'b0;
        end else if (fall_en) begin
            addr_q  <= saddr_q;
            din_q   <= sdata_q;
            cs_n_q  <= ~slot_q | (scmd_q == sram_scan_pkg::CMD_PASS);
            we_n_q  <= ~slot_q | (scmd_q == sram_scan_pkg::CMD_READ);
            oe_n_q  <= ~tag_a_q;
            tag_a_q <= slot_q & sdrv_q;
            tag_b_q <= tag_a_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
        end else begin
            rsp_valid <= fall_en & tag_b_q;
            if (fall_en && tag_b_q) begin
                rsp_data <= link.dout_pin;
            end
        end
    end

    // Scan sequence: wait, capture rise, raise hold, 39 shifts, recover
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q      <= sram_scan_pkg::H_RUN;
            tmr_q     <= '0;
            bits_q    <= '0;
            sck_q     <= 1'b0;
            hold_q    <= 1'b0;
            scan_word <= '0;
            scan_done <= 1'b0;
            scan_busy <= 1'b0;
        end else begin
            scan_done <= 1'b0;
            tmr_q     <= tmr_q + 8'h01;
            case (st_q)
                sram_scan_pkg::H_RUN: begin
                    tmr_q <= '0;
                    if (start_scan) begin
                        st_q      <= sram_scan_pkg::H_SETUP;
                        scan_busy <= 1'b1;
                    end
                end
                sram_scan_pkg::H_SETUP: begin
                    if (tmr_q == 8'(`SCAN_SETUP_CYC - 1)) begin
                        st_q  <= sram_scan_pkg::H_CAP_HI;
                        sck_q <= 1'b1;
                        tmr_q <= '0;
                    end
                end
                sram_scan_pkg::H_CAP_HI: begin
                    if (tmr_q == 8'(`SCAN_HALF_CYC - 1)) begin
                        st_q  <= sram_scan_pkg::H_CAP_LO;
                        sck_q <= 1'b0;
                        tmr_q <= '0;
                    end
                end
                sram_scan_pkg::H_CAP_LO: begin
                    if (tmr_q == 8'(`HOLD_GAP_CYC)) begin
                        hold_q <= 1'b1;
                    end
                    if (tmr_q == 8'(`SCAN_HALF_CYC - 1)) begin
                        st_q   <= sram_scan_pkg::H_SH_HI;
                        sck_q  <= 1'b1;
                        tmr_q  <= '0;
                        bits_q <= 6'h01;
                        scan_word <= {link.scan_out, scan_word[LEN-1:1]};
                    end
                end
                sram_scan_pkg::H_SH_HI: begin
                    if (tmr_q == 8'(`SCAN_HALF_CYC - 1)) begin
                        st_q  <= (bits_q == 6'(LEN)) ? sram_scan_pkg::H_RECOVER
                                                     : sram_scan_pkg::H_SH_LO;
                        sck_q <= 1'b0;
                        tmr_q <= '0;
                    end
                end
                sram_scan_pkg::H_SH_LO: begin
                    if (tmr_q == 8'(`SCAN_HALF_CYC - 1)) begin
                        st_q   <= sram_scan_pkg::H_SH_HI;
                        sck_q  <= 1'b1;
                        tmr_q  <= '0;
                        bits_q <= bits_q + 6'h01;
                        scan_word <= {link.scan_out, scan_word[LEN-1:1]};
                    end
                end
                sram_scan_pkg::H_RECOVER: begin
                    hold_q <= 1'b0;
                    if (tmr_q == 8'(`SCAN_RECOV_CYC - 1)) begin
                        st_q      <= sram_scan_pkg::H_RUN;
                        scan_busy <= 1'b0;
                        scan_done <= 1'b1;
                    end
                end
                default: begin
                    st_q <= sram_scan_pkg::H_RUN;
                end
            endcase
        end
    end

    assign link.array_clock       = ak_q;
    assign link.addr_bus          = addr_q;
    assign link.din_bus           = din_q;
    assign link.chip_select_n     = cs_n_q;
    assign link.write_strobe_n    = we_n_q;
    assign link.output_drive_n    = oe_n_q;
    assign link.scan_clk          = sck_q;
    assign link.scan_capture_hold = hold_q;
    assign link.scan_in           = 1'b0;
endmodule
`default_nettype wire

// ===== verilog/sram_link_if.sv
// Pin-level link between the memory controller and the SRAM device
`timescale 1ns/1ps
`default_nettype none
`include "sram_scan_map.svh"
interface sram_link_if;
    // Array side
    logic                 array_clock;
    logic [`ADDR_W-1:0]   addr_bus;
    logic [`DATA_W-1:0]   din_bus;
    logic                 chip_select_n;
    logic                 write_strobe_n;
    logic                 output_drive_n;
    logic [`DATA_W-1:0]   dout_bus;
    logic                 dout_oe;
    logic [`DATA_W-1:0]   dout_pin;
    // Scan side
    logic                 scan_clk;
    logic                 scan_capture_hold;
    logic                 scan_in;
    logic                 scan_out;

    // A floating bus shows the inverse word, so a missed drive never reads as data
    assign dout_pin = dout_oe ? dout_bus : ~dout_bus;

    modport device (
        input  array_clock, addr_bus, din_bus, chip_select_n, write_strobe_n,
        input  output_drive_n, scan_clk, scan_capture_hold, scan_in,
        output dout_bus, dout_oe, scan_out
    );
    modport host (
        output array_clock, addr_bus, din_bus, chip_select_n, write_strobe_n,
        output output_drive_n, scan_clk, scan_capture_hold, scan_in,
        input  dout_pin, scan_out
    );
endinterface
`default_nettype wire

// ===== verilog/sram_scan_map.svh
// Constants of the scan-equipped synchronous SRAM: geometry, chain and timing
`ifndef SRAM_SCAN_MAP_SVH
`define SRAM_SCAN_MAP_SVH

`define ADDR_W          17
`define DATA_W          9
`define MEM_DEPTH       131072
`define CHAIN_LEN       39

`define CLK_NS          5
`define ARRAY_HALF_CYC  2

`define SCAN_CYCLE_NS   100
`define SCAN_HALF_CYC   ((`SCAN_CYCLE_NS + 2 * `CLK_NS - 1) / (2 * `CLK_NS))
`define SCAN_SETUP_NS   10
`define SCAN_SETUP_CYC  ((`SCAN_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define SCAN_RECOV_NS   100
`define SCAN_RECOV_CYC  ((`SCAN_RECOV_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_GAP_NS     10
`define HOLD_GAP_CYC    ((`HOLD_GAP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== verilog/sram_scan_pkg.sv
// Types of the scan-equipped SRAM link: device modes, commands and controller states
`default_nettype none
package sram_scan_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h1,
        MODE_SCAN   = 3'h2,
        MODE_BYPASS = 3'h4
    } dev_mode_t;

    typedef enum logic [1:0] {
        CMD_READ  = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_PASS  = 2'h2
    } cmd_t;

    typedef enum logic [6:0] {
        H_RUN     = 7'h01,
        H_SETUP   = 7'h02,
        H_CAP_HI  = 7'h04,
        H_CAP_LO  = 7'h08,
        H_SH_HI   = 7'h10,
        H_SH_LO   = 7'h20,
        H_RECOVER = 7'h40
    } host_state_t;
endpackage
`default_nettype wire
